/* File: hdl/asr_device.sv */
/*
  Converter end: conversion timer, result register and serial readout.
  Assumes the host drives sclk, cs_n, rd_n and convert_start_n; clk_i
  is the core clock, sclk the link clock of its own domain.
*/
// Function
// - After busy falls, result readable when selected
// - Sixteen bits MSB first, stable both edges
// - Serial clock up to 80 MHz
// - Chain input only in read-after mode
// - Chain input captured on opposite edge
// - Chain bits follow own LSB directly
// - Host shares one convert start signal
// - During conversion, previous result shifted out
// - Host reads all bits before conversion ends
// - Early conversion end pulses read error
// - Chain input held fixed in read-during mode
// - Host uses fast clock reading during conversion
// - Host avoids reads spanning conversion start
// - Host uses polarity 0, phase 1
// - Example host limits clock to 17 Mb/s; asr_host here runs sclk at 50 MHz
// - Host starts read on busy falling edge
// - Serial clock ignored without chip select
// - External clock used when source select high
// - Serial port active when select high
// - Outputs high impedance when cs or rd high
`timescale 1ns/1ps
module asr_device
  import asr_pkg::*;
#(
  parameter int CONV_CYC = ASR_CONV_CYC
) (
  // Core clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // Strap and mode inputs
  input  wire logic        clock_source_select_i,
  input  wire logic        serial_parallel_select_i,
  input  wire logic        read_during_conv_i,
  // Sample to convert, user side
  input  wire logic [15:0] sample_i,
  // Link
  asr_link_if.device       link
);
  // Conversion counter is 16 bits wide and needs two cycles at least
  if (CONV_CYC < 2 || CONV_CYC > 65535) begin : g_bad_conv_cyc
    $error("asr_device: CONV_CYC out of range");
  end

  typedef enum logic [1:0] {
    ASR_IDLE = 2'b01,
    ASR_CONV = 2'b10
  } asr_state_t;

  // ----------------------------------------------------------------
  // Core domain: synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cnv_sync;
  logic [1:0] done_sync;
  logic       cnv_prev;
  logic       done_prev;
  logic       done_tgl;

  // Two flops for every level from the link side
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnv_sync  <= 2'b11;
      done_sync <= 2'b00;
      cnv_prev  <= 1'b1;
      done_prev <= 1'b0;
    end else if (ce_i) begin
      cnv_sync  <= {cnv_sync[0], link.convert_start_n};
      done_sync <= {done_sync[0], done_tgl};
      cnv_prev  <= cnv_sync[1];
      done_prev <= done_sync[1];
    end
  end

  // ----------------------------------------------------------------
  // Core domain: conversion and result
  // ----------------------------------------------------------------
  asr_state_t  state;
  asr_state_t  next_state;
  logic [15:0] conv_cnt;
  logic [15:0] next_conv_cnt;
  logic [15:0] result;
  logic [15:0] next_result;
  logic        busy;
  logic        next_busy;
  logic        err;
  logic        next_err;
  logic        read_open;
  logic        next_read_open;
  logic        word_done;

  assign word_done = done_sync[1] ^ done_prev;

  // Next-state logic of the conversion timer
  always_comb begin
    next_state     = state;
    next_conv_cnt  = conv_cnt;
    next_result    = result;
    next_busy      = busy;
    next_err       = 1'b0;
    next_read_open = read_open;
    if (word_done) begin
      next_read_open = 1'b0;
    end
    case (state)
      ASR_IDLE: begin
        if (cnv_prev && !cnv_sync[1]) begin
          next_state    = ASR_CONV;
          next_conv_cnt = 16'(CONV_CYC - 1);
          next_busy     = 1'b1;
        end
      end
      ASR_CONV: begin
        if (conv_cnt == 16'h0000) begin
          next_state  = ASR_IDLE;
          next_busy   = 1'b0;
          next_result = sample_i;
          // Previous word not fully read by now
          if (read_during_conv_i && read_open && !word_done) begin
            next_err = 1'b1;
          end
          next_read_open = 1'b1;
        end else begin
          next_conv_cnt = conv_cnt - 16'h0001;
        end
      end
      default: begin
        next_state = ASR_IDLE;
        next_busy  = 1'b0;
      end
    endcase
  end

  // Registers of the conversion timer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= ASR_IDLE;
      conv_cnt  <= 16'h0000;
      result    <= ASR_RESULT_RST;
      busy      <= 1'b0;
      err       <= 1'b0;
      read_open <= 1'b0;
    end else if (ce_i) begin
      state     <= next_state;
      conv_cnt  <= next_conv_cnt;
      result    <= next_result;
      busy      <= next_busy;
      err       <= next_err;
      read_open <= next_read_open;
    end
  end

  assign link.busy               = busy;
  assign link.read_overrun_error = err;

  // ----------------------------------------------------------------
  // Link domain: shift register on sclk
  // ----------------------------------------------------------------
  logic        port_on;
  logic        frame_rst_n;
  logic [14:0] shreg;
  logic [14:0] next_shreg;
  logic [4:0]  bitcnt;
  logic [4:0]  next_bitcnt;
  logic        tgl;
  logic        next_tgl;
  logic        chain_bit;
  logic        sdo_q;
  logic        next_sdo_q;

  // Serial slave mode needs both straps high
  assign port_on = serial_parallel_select_i
                 && clock_source_select_i;
  // Frame counter restarts whenever the host deselects
  assign frame_rst_n = rst_n_i && !link.cs_n;

  // Chain input latched on the falling edge, opposite to shift
  always_ff @(negedge link.sclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain_bit <= 1'b0;
    end else if (!link.cs_n) begin
      chain_bit <= link.chain_data_in;
    end
  end

  // Next shift state: load on first edge, then shift MSB first
  always_comb begin
    next_shreg  = shreg;
    next_bitcnt = bitcnt;
    next_sdo_q  = sdo_q;
    next_tgl    = tgl;
    if (bitcnt == ASR_BITCNT_RST) begin
      // Word crossed as a whole; result changes only at conversion end, keeping it stable
      next_shreg  = result[14:0];
      next_sdo_q  = result[15];
      next_bitcnt = 5'h01;
    end else begin
      // Fifteen bits held, so the first chain bit follows the LSB
      next_sdo_q  = shreg[14];
      next_shreg  = {shreg[13:0],
                     read_during_conv_i ? 1'b0 : chain_bit};
      // Sixteenth rise puts out the LSB: word complete
      if (bitcnt == 5'(ASR_WORD_BITS - 1)) begin
        next_tgl = ~tgl;
      end
      if (bitcnt != 5'h1F) begin
        next_bitcnt = bitcnt + 5'h01;
      end
    end
  end

  // One sdo change per rising edge, held a full period
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shreg  <= ASR_RESULT_RST[14:0];
      bitcnt <= ASR_BITCNT_RST;
      sdo_q  <= 1'b0;
    end else if (!link.rd_n && port_on) begin
      shreg  <= next_shreg;
      bitcnt <= next_bitcnt;
      sdo_q  <= next_sdo_q;
    end
  end

  // Completion toggle survives deselect, read at the cs_n rise
  always_ff @(posedge link.sclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl <= 1'b0;
    end else if (!link.cs_n && !link.rd_n && port_on) begin
      tgl <= next_tgl;
    end
  end

  // Completion toggle handed to the core domain when the host deselects
  always_ff @(posedge link.cs_n or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_tgl <= 1'b0;
    end else begin
      done_tgl <= tgl;
    end
  end

  assign link.sdo      = sdo_q;
  // Driven only while selected and in serial mode
  assign link.sdo_oe_n = link.cs_n || link.rd_n || !port_on;
endmodule : asr_device

/* File: hdl/asr_pkg.sv */
/*
  Constants shared by both ends of the serial result readout link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package asr_pkg;
  // ----------------------------------------------------------------
  // Word format
  // ----------------------------------------------------------------
  localparam int           ASR_WORD_BITS    = 16;
  localparam logic [15:0]  ASR_RESULT_RST   = 16'h0000;
  localparam logic [4:0]   ASR_BITCNT_RST   = 5'h00;
  // ----------------------------------------------------------------
  // Timing of the device model and host divider
  // ----------------------------------------------------------------
  localparam int           ASR_CLK_MHZ      = 200;
  localparam int           ASR_SCLK_MAX_MHZ = 80;
  // Conversion time in ns; cycles derived from the 200 MHz rate
  localparam int           ASR_CONV_NS      = 300;
  localparam int           ASR_CONV_CYC     = (ASR_CONV_NS * ASR_CLK_MHZ) / 1000;
  // Least half period of the host serial clock, cycles (rounds up)
  localparam int           ASR_HALF_CYC     =
    (ASR_CLK_MHZ + 2 * ASR_SCLK_MAX_MHZ - 1) / (2 * ASR_SCLK_MAX_MHZ);
endpackage : asr_pkg

/* File: hdl/asr_link_if.sv */
/*
  Link between the converter readout port and the host serial master.
  Assumes the device end is clocked by sclk, driven by the host end.
*/
`timescale 1ns/1ps
interface asr_link_if;
  logic sclk;          // Host serial clock, idle low
  logic cs_n;          // Chip select, active low
  logic rd_n;          // Read enable, active low
  logic convert_start_n; // Shared conversion start, falling edge
  logic busy;          // Conversion in progress
  logic sdo;           // Serial data out level
  logic sdo_oe_n;      // Low while device drives sdo
  logic chain_data_in; // Daisy-chain input
  logic read_overrun_error; // Incomplete read pulse
  // Resolved wire level seen by the host
  logic sdo_wire;
  assign sdo_wire = sdo_oe_n ? 1'b0 : sdo;

  modport device (
    input  sclk, cs_n, rd_n, convert_start_n, chain_data_in,
    output busy, sdo, sdo_oe_n, read_overrun_error
  );
  modport host (
    input  busy, sdo_wire, read_overrun_error,
    output sclk, cs_n, rd_n, convert_start_n, chain_data_in
  );
endinterface : asr_link_if

/* File: hdl/asr_host.sv */
/*
  Host end: serial master that starts a conversion, waits for busy to
  fall and clocks out one word with polarity 0, phase 1.
  Assumes the device end samples sclk, cs_n, rd_n on the link.
*/
`timescale 1ns/1ps
module asr_host
  import asr_pkg::*;
#(
  parameter int HALF_CYC = ASR_HALF_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // User request and answer
  input  wire logic        start_i,
  output logic             done_o,
  output logic [15:0]      data_o,
  output logic             error_o,
  // Link
  asr_link_if.host         link
);
  // Data synchroniser needs two cycles of each half period
  if (HALF_CYC < 2 || HALF_CYC > 255) begin : g_bad_half_cyc
    $error("asr_host: HALF_CYC out of range");
  end

  typedef enum logic [3:0] {
    AH_IDLE = 4'b0001,
    AH_CNV  = 4'b0010,
    AH_WAIT = 4'b0100,
    AH_SHFT = 4'b1000
  } ah_state_t;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] busy_s;
  logic [1:0] sdo_s;
  logic [1:0] err_s;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_s <= 2'b00;
      sdo_s  <= 2'b00;
      err_s  <= 2'b00;
    end else if (ce_i) begin
      busy_s <= {busy_s[0], link.busy};
      sdo_s  <= {sdo_s[0], link.sdo_wire};
      err_s  <= {err_s[0], link.read_overrun_error};
    end
  end

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  ah_state_t   st, next_st;
  logic [7:0]  div, next_div;
  logic [4:0]  cnt, next_cnt;
  logic [15:0] sh, next_sh;
  logic        sclk, next_sclk;
  logic        cs_n, next_cs_n;
  logic        cnv_n, next_cnv_n;
  logic        done, next_done;
  logic        err, next_err;
  logic        pend, next_pend;

  // Next values of the sequencer
  always_comb begin
    next_st        = st;
    next_div       = div;
    next_cnt       = cnt;
    next_sh        = sh;
    next_sclk      = sclk;
    next_cs_n      = cs_n;
    next_cnv_n     = cnv_n;
    next_done      = 1'b0;
    next_err       = err | err_s[1];
    next_pend      = 1'b0;
    case (st)
      AH_IDLE: begin
        // New conversion only once the last read has ended
        if (start_i) begin
          next_st    = AH_CNV;
          next_cnv_n = 1'b0;
          next_err   = 1'b0;
        end
      end
      AH_CNV: begin
        if (busy_s[1]) begin
          next_cnv_n     = 1'b1;
          next_st        = AH_WAIT;
        end
      end
      AH_WAIT: begin
        // Read begins on busy falling
        if (!busy_s[1]) begin
          next_st   = AH_SHFT;
          next_cs_n = 1'b0;
          next_div  = 8'(HALF_CYC - 1);
          next_cnt  = 5'h00;
        end
      end
      AH_SHFT: begin
        // Bit taken one cycle after the fall, through the synchroniser
        if (pend) begin
          next_sh = {sh[14:0], sdo_s[1]};
          if (cnt == 5'(ASR_WORD_BITS)) begin
            next_st   = AH_IDLE;
            next_cs_n = 1'b1;
            next_done = 1'b1;
          end
        end
        if (div != 8'h00) begin
          next_div = div - 8'h01;
        end else if (cnt != 5'(ASR_WORD_BITS)) begin
          next_div  = 8'(HALF_CYC - 1);
          // Idle low clock, sample on falling edge
          next_sclk = ~sclk;
          if (sclk) begin
            next_cnt  = cnt + 5'h01;
            next_pend = 1'b1;
          end
        end
      end
      default: begin
        next_st = AH_IDLE;
      end
    endcase
  end

  // Registers of the sequencer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st        <= AH_IDLE;
      div       <= 8'h00;
      cnt       <= 5'h00;
      sh        <= 16'h0000;
      sclk      <= 1'b0;
      cs_n      <= 1'b1;
      cnv_n     <= 1'b1;
      done      <= 1'b0;
      err       <= 1'b0;
      pend      <= 1'b0;
    end else if (ce_i) begin
      st        <= next_st;
      div       <= next_div;
      cnt       <= next_cnt;
      sh        <= next_sh;
      sclk      <= next_sclk;
      cs_n      <= next_cs_n;
      cnv_n     <= next_cnv_n;
      done      <= next_done;
      err       <= next_err;
      pend      <= next_pend;
    end
  end

  assign link.sclk            = sclk;
  assign link.cs_n            = cs_n;
  assign link.rd_n            = cs_n;
  assign link.convert_start_n = cnv_n;
  assign link.chain_data_in   = 1'b0;
  assign done_o  = done;
  assign data_o  = sh;
  assign error_o = err;
endmodule : asr_host

/* File: verif/asr_link_assertions.sv */
/*
  Checker for the link between the device and host ends.
  Assumes it sits beside the joined link and samples it on clk_i.
*/
`timescale 1ns/1ps
module asr_link_assertions #(
  parameter int CONV_CYC = 60
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Link signals
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic rd_n,
  input  wire logic convert_start_n,
  input  wire logic busy,
  input  wire logic sdo,
  input  wire logic sdo_oe_n,
  input  wire logic chain_data_in,
  input  wire logic read_overrun_error,
  input  wire logic sdo_wire
);
  localparam int BUSY_MIN = CONV_CYC - 10;
  localparam int BUSY_MAX = CONV_CYC + 10;
  logic [4:0] rise_cnt;
  logic       sclk_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Counts serial clock rises within one selected frame
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_cnt <= 5'h00;
      sclk_q   <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (cs_n) rise_cnt <= 5'h00;
      else if (sclk && !sclk_q) rise_cnt <= rise_cnt + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  tristate_off_a: assert property (
    (cs_n || rd_n) |-> sdo_oe_n) else $error("sdo driven while off");
  drive_on_a: assert property (
    (!cs_n && !rd_n) |-> !sdo_oe_n) else $error("sdo not driven");
  sclk_idle_a: assert property (
    cs_n |-> !sclk) else $error("serial clock runs unselected");
  bit_stable_a: assert property (
    ($fell(sclk) && !cs_n) |-> $stable(sdo))
    else $error("sdo moved at falling edge");
  pulse_count_a: assert property (
    $rose(cs_n) |-> (rise_cnt == 5'h10)) else $error("frame not 16 pulses");
  busy_len_a: assert property (
    $rose(busy) |-> ##[BUSY_MIN:BUSY_MAX] $fell(busy))
    else $error("conversion length wrong");
  start_busy_a: assert property (
    $fell(convert_start_n) |-> ##[1:6] busy) else $error("busy not raised");
  read_start_a: assert property (
    $fell(busy) |-> ##[1:6] !cs_n) else $error("read not started");
  err_pulse_a: assert property (
    $rose(read_overrun_error) |=> !read_overrun_error)
    else $error("error pulse too long");
  chain_fixed_a: assert property (
    $stable(chain_data_in)) else $error("chain input moved");

  // Main scenarios reached
  frame_c: cover property ($rose(cs_n) && rise_cnt == 5'h10);
  conv_c: cover property ($fell(busy));
  drive_c: cover property ($fell(sdo_oe_n));
endmodule : asr_link_assertions

/* File: verif/test_adc_slave_serial_readout.sv */
/*
  Bench: host and device joined, plus a second device driven by hand.
  Assumes the design files and the link checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
  fail_count++; $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module test_adc_slave_serial_readout
  import asr_pkg::*;
;
  localparam int CONV2 = 400;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        ce      = 1'b1;
  logic        strap   = 1'b1;
  logic        rdc1    = 1'b0;
  logic        rdc2    = 1'b0;
  logic        start   = 1'b0;
  logic [15:0] smp1    = 16'h0000;
  logic [15:0] smp2    = 16'h0000;
  logic [15:0] cap;
  logic [31:0] got;
  logic        done;
  logic        err;
  logic [15:0] data;
  int          n;
  int          fail_count   = 0;
  int          total_checks = 0;
  logic [15:0] words [5] = '{16'hA5C3, 16'h0001, 16'h8000, 16'hFFFF,
                             16'h0000};

  // Core clock, 200 MHz
  always #2.5 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Links, ends and checker
  // ----------------------------------------------------------------
  asr_link_if l1 ();
  asr_link_if l2 ();
  asr_device i_asr_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .clock_source_select_i(strap), .serial_parallel_select_i(strap),
    .read_during_conv_i(rdc1), .sample_i(smp1), .link(l1));
  asr_host i_asr_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .start_i(start), .done_o(done), .data_o(data), .error_o(err),
    .link(l1));
  asr_device #(.CONV_CYC(CONV2)) i_asr_device_2 (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .ce_i(ce), .clock_source_select_i(strap),
    .serial_parallel_select_i(strap), .read_during_conv_i(rdc2),
    .sample_i(smp2), .link(l2));
  asr_link_assertions #(.CONV_CYC(ASR_CONV_CYC)) i_asr_link_assertions (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk(l1.sclk), .cs_n(l1.cs_n),
    .rd_n(l1.rd_n), .convert_start_n(l1.convert_start_n),
    .busy(l1.busy), .sdo(l1.sdo), .sdo_oe_n(l1.sdo_oe_n),
    .chain_data_in(l1.chain_data_in),
    .read_overrun_error(l1.read_overrun_error), .sdo_wire(l1.sdo_wire));

  // Wire-level capture at the host sampling edge
  always @(negedge l1.sclk) cap <= {cap[14:0], l1.sdo_wire};

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // One conversion and read through the host end
  task automatic host_word(input logic [15:0] s, input logic rd);
    int k;
    k = 0;
    @(posedge clk_i);
    smp1  <= s;
    rdc1  <= rd;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    while (done !== 1'b1 && k < 1000) begin
      @(negedge clk_i);
      k++;
    end
    `CHK("done", 1'b1, done)
    `CHK("error", 1'b0, err)
    `CHK("data", s, data)
    `CHK("wire bits", s, cap)
  endtask : host_word

  // Conversion start on the hand-driven device
  task automatic conv2(input logic [15:0] s);
    @(posedge clk_i);
    smp2 <= s;
    l2.convert_start_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    l2.convert_start_n <= 1'b1;
  endtask : conv2

  task automatic wait_busy2;
    int k;
    k = 0;
    repeat (8) @(negedge clk_i);
    while (l2.busy !== 1'b0 && k < 2000) begin
      @(negedge clk_i);
      k++;
    end
    `CHK("busy end", 1'b0, l2.busy)
  endtask : wait_busy2

  // Frame on a 125 ns link clock; chain bits change after each of the first eight rises
  task automatic shift2(input int nb, input logic [7:0] ch);
    got = 32'h0;
    #17;
    l2.cs_n = 1'b0;
    l2.rd_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      #62.5;
      l2.sclk = 1'b1;
      #10;
      if (i < 8) l2.chain_data_in = ch[7 - i];
      #52.5;
      got = {got[30:0], l2.sdo_wire};
      l2.sclk = 1'b0;
    end
    #62.5;
  endtask : shift2

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    l2.sclk = 1'b0;
    l2.cs_n = 1'b1;
    l2.rd_n = 1'b1;
    l2.convert_start_n = 1'b1;
    l2.chain_data_in = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (words[k]) host_word(words[k], 1'b0);
    host_word(16'h3C5A, 1'b1);
    host_word(16'hC3A5, 1'b1);
    conv2(16'h5A3C);
    wait_busy2();
    shift2(24, 8'hC6);
    `CHK("chain", {16'h5A3C, 8'hC6}, got[23:0])
    l2.cs_n = 1'b1;
    l2.rd_n = 1'b1;
    #1;
    `CHK("tristate", 1'b1, l2.sdo_oe_n)
    rdc2 = 1'b1;
    conv2(16'h9C71);
    wait_busy2();
    conv2(16'h1234);
    shift2(8, 8'h00);
    `CHK("previous word", 8'h9C, got[7:0])
    n = 0;
    while (l2.read_overrun_error !== 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("read error", 1'b1, l2.read_overrun_error)
    l2.cs_n = 1'b1;
    l2.rd_n = 1'b1;
    give_verdict();
  end

  // Cuts a hang short
  initial begin
    #150000;
    fail_count++;
    give_verdict();
  end
endmodule : test_adc_slave_serial_readout
